/* File: common/egrb_map.svh */
// Register offsets, reset values and limits of the exposure register bank
`ifndef EGRB_MAP_SVH
`define EGRB_MAP_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define EGRB_SETUP1_OFS 8'h11
`define EGRB_FINE_HI_OFS 8'h20
`define EGRB_FINE_LO_OFS 8'h21
`define EGRB_COARSE_HI_OFS 8'h22
`define EGRB_COARSE_LO_OFS 8'h23
`define EGRB_GAIN_OFS 8'h24
`define EGRB_CLKDIV_OFS 8'h25
`define EGRB_STATUS_OFS 8'h26
`define EGRB_DARK_HI_OFS 8'h2c
`define EGRB_DARK_LO_OFS 8'h2d
`define EGRB_DARK_CTRL_OFS 8'h2e
`define EGRB_PAGE_HI 4'h2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EGRB_SETUP1_SHUF_BIT 7
`define EGRB_SETUP1_IMM_GAIN_BIT 4
`define EGRB_SETUP1_IMM_DIV_BIT 3
`define EGRB_DARK_SLOW_BIT 3
`define EGRB_STATUS_PEND_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define EGRB_SETUP1_RST 8'h80
`define EGRB_FINE_RST 10'h000
`define EGRB_COARSE_RST 10'h20a
`define EGRB_GAIN_RST 4'h0
`define EGRB_CLKDIV_RST 4'h0
`define EGRB_DARK_RST 11'h000
`define EGRB_DARK_CTRL_RST 8'h00
`define EGRB_PIX_MAX 10'h3ff

`endif

/* File: common/egrb_pkg.sv */
// Types shared by the exposure register bank
package egrb_pkg;
  typedef logic [9:0] egrb_exp_t;
  typedef logic [3:0] egrb_code_t;
  typedef logic signed [10:0] egrb_offset_t;
  typedef enum logic [1:0] {
    EGRB_DARK_REPORT = 2'b00,
    EGRB_DARK_INTERNAL = 2'b01,
    EGRB_DARK_EXTERNAL = 2'b11
  } egrb_dark_mode_t;
endpackage

/* File: rtl/egrb_bank.sv */
// Exposure and gain register bank with frame-boundary hand-over
//
// Behaviour
// R1 - New fine, coarse, gain and divisor values are picked up only at a frame start.
// R2 - Reads return the locally held, most recently written value.
// R3 - Status bit 0 is set from an exposure write until that data is in use.
// R4 - Gain takes effect one frame after the other exposure values.
// R5 - Hand-over is suspended while any exposure page location is written.
// R6 - Values above their permitted range are clipped to the maximum.
// R7 - Fine exposure is 10 bits split over 0x20 (bits 9:8) and 0x21, reset 0.
// R8 - Coarse exposure is 10 bits split over 0x22 and 0x23, reset 522.
// R9 - The 4-bit gain code at 0x24 selects 1.0 up to 16, reset 0.
// R10 - Gain drives the output stage amplifier and leaves integration alone.
// R11 - Divisor code 0 divides by 1, 1 by 2, otherwise 2*(code[3:1]+1).
// R12 - The dark offset is 11-bit two's complement at 0x2c/0x2d added to pixels.
// R13 - With immediate gain update set a gain write applies at once.
// R14 - With immediate divisor update set a divisor write applies at once.
// R15 - Dark mode 00 reports only, 01 applies internal, 11 external offset.
// R16 - The pending bit clears once all pending values, gain included, are used.
`timescale 1ns/1ps
`include "egrb_map.svh"

module egrb_bank (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_page_busy,
  input wire logic i_frame_start,
  input wire egrb_pkg::egrb_exp_t i_line_max,
  input wire egrb_pkg::egrb_exp_t i_frame_max,
  input wire logic i_pix_valid,
  input wire logic [9:0] i_pix,
  input wire egrb_pkg::egrb_offset_t i_dark_calc,
  output logic [7:0] o_rdata,
  output egrb_pkg::egrb_exp_t o_fine_exp,
  output egrb_pkg::egrb_exp_t o_coarse_exp,
  output egrb_pkg::egrb_code_t o_gain_code,
  output logic [4:0] o_clk_div_ratio,
  output egrb_pkg::egrb_dark_mode_t o_dark_mode,
  output logic o_dark_slow,
  output logic o_exp_pending,
  output logic o_pix_valid,
  output logic [9:0] o_pix
);
  import egrb_pkg::*;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic in_page;
  logic wr_retimed;
  logic imm_gain;
  logic imm_div;
  logic frozen;
  logic handover;
  logic [7:0] setup1_q;
  egrb_exp_t fine_sh_q;
  egrb_exp_t coarse_sh_q;
  egrb_code_t gain_sh_q;
  egrb_code_t div_sh_q;
  egrb_offset_t dark_ofs_q;
  logic [7:0] dark_ctrl_q;
  egrb_code_t gain_stage_q;
  egrb_code_t div_act_q;
  logic gain_wait_q;
  logic exp_pend_q;

  assign in_page = i_addr[7:4] == `EGRB_PAGE_HI;
  assign imm_gain = setup1_q[`EGRB_SETUP1_IMM_GAIN_BIT];
  assign imm_div = setup1_q[`EGRB_SETUP1_IMM_DIV_BIT];
  // A write applied at once needs no frame re-timing
  assign wr_retimed = i_wr_en && in_page && i_addr <= `EGRB_CLKDIV_OFS
    && !(i_addr == `EGRB_GAIN_OFS && imm_gain)
    && !(i_addr == `EGRB_CLKDIV_OFS && imm_div);
  // Holding off during a burst keeps a split update from reaching the array
  assign frozen = i_page_busy || (i_wr_en && in_page); // [R5]
  assign handover = i_frame_start && !frozen; // [R1]

  // ----------------------------------------------------------------------
  // Locally held register values
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      setup1_q <= `EGRB_SETUP1_RST;
      fine_sh_q <= `EGRB_FINE_RST;
      coarse_sh_q <= `EGRB_COARSE_RST;
      gain_sh_q <= `EGRB_GAIN_RST;
      div_sh_q <= `EGRB_CLKDIV_RST;
      dark_ofs_q <= `EGRB_DARK_RST;
      dark_ctrl_q <= `EGRB_DARK_CTRL_RST;
    end else if (i_wr_en) begin
      case (i_addr)
        `EGRB_SETUP1_OFS: setup1_q <= i_wdata;
        `EGRB_FINE_HI_OFS: fine_sh_q[9:8] <= i_wdata[1:0]; // [R7]
        `EGRB_FINE_LO_OFS: fine_sh_q[7:0] <= i_wdata; // [R7]
        `EGRB_COARSE_HI_OFS: coarse_sh_q[9:8] <= i_wdata[1:0]; // [R8]
        `EGRB_COARSE_LO_OFS: coarse_sh_q[7:0] <= i_wdata; // [R8]
        `EGRB_GAIN_OFS: gain_sh_q <= i_wdata[3:0]; // [R9]
        `EGRB_CLKDIV_OFS: div_sh_q <= i_wdata[3:0];
        `EGRB_DARK_HI_OFS: dark_ofs_q[10:8] <= i_wdata[2:0]; // [R12]
        `EGRB_DARK_LO_OFS: dark_ofs_q[7:0] <= i_wdata; // [R12]
        `EGRB_DARK_CTRL_OFS: dark_ctrl_q <= i_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read-back of the stored, possibly unconsumed values
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd_en) begin
      case (i_addr) // [R2]
        `EGRB_SETUP1_OFS: o_rdata <= setup1_q & 8'h98;
        `EGRB_FINE_HI_OFS: o_rdata <= {6'h00, fine_sh_q[9:8]};
        `EGRB_FINE_LO_OFS: o_rdata <= fine_sh_q[7:0];
        `EGRB_COARSE_HI_OFS: o_rdata <= {6'h00, coarse_sh_q[9:8]};
        `EGRB_COARSE_LO_OFS: o_rdata <= coarse_sh_q[7:0];
        `EGRB_GAIN_OFS: o_rdata <= {4'h0, gain_sh_q};
        `EGRB_CLKDIV_OFS: o_rdata <= {4'h0, div_sh_q};
        `EGRB_STATUS_OFS: o_rdata <= {7'h00, o_exp_pending}; // [R3]
        `EGRB_DARK_HI_OFS: o_rdata <= {5'h00, dark_ofs_q[10:8]};
        `EGRB_DARK_LO_OFS: o_rdata <= dark_ofs_q[7:0];
        `EGRB_DARK_CTRL_OFS: o_rdata <= dark_ctrl_q & 8'h0b;
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Frame-boundary hand-over to the exposure logic
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_fine_exp <= `EGRB_FINE_RST;
      o_coarse_exp <= `EGRB_COARSE_RST;
    end else if (handover) begin
      o_fine_exp <= (fine_sh_q > i_line_max) ? i_line_max : fine_sh_q; // [R6]
      o_coarse_exp <= (coarse_sh_q > i_frame_max) ?
        i_frame_max : coarse_sh_q; // [R6]
    end
  end

  // Gain is staged at one boundary and driven at the next
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      gain_stage_q <= `EGRB_GAIN_RST;
      gain_wait_q <= 1'b0;
      o_gain_code <= `EGRB_GAIN_RST;
    end else if (i_wr_en && i_addr == `EGRB_GAIN_OFS && imm_gain) begin
      o_gain_code <= i_wdata[3:0]; // [R13] [R10]
      gain_stage_q <= i_wdata[3:0];
      gain_wait_q <= 1'b0;
    end else if (handover) begin
      if (gain_wait_q) begin
        o_gain_code <= gain_stage_q; // [R4]
      end
      gain_stage_q <= gain_sh_q;
      gain_wait_q <= exp_pend_q; // [R4]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      div_act_q <= `EGRB_CLKDIV_RST;
    end else if (i_wr_en && i_addr == `EGRB_CLKDIV_OFS && imm_div) begin
      div_act_q <= i_wdata[3:0]; // [R14]
    end else if (handover) begin
      div_act_q <= div_sh_q; // [R1]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_clk_div_ratio <= 5'h01;
    end else if (div_act_q[3:1] == 3'h0) begin
      o_clk_div_ratio <= {3'h0, div_act_q[0], !div_act_q[0]}; // [R11]
    end else begin
      // Widened before the add so that code 111x reaches 16, not 0
      o_clk_div_ratio <= {{1'b0, div_act_q[3:1]} + 4'h1, 1'b0}; // [R11]
    end
  end

  // ----------------------------------------------------------------------
  // Pending status
  // ----------------------------------------------------------------------
  // A write blocks the hand-over in its own cycle, so a new write always
  // wins over the clear of the boundary that it collides with
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      exp_pend_q <= 1'b0;
    end else if (wr_retimed) begin
      exp_pend_q <= 1'b1; // [R3]
    end else if (handover) begin
      exp_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_exp_pending <= 1'b0;
    end else begin
      o_exp_pending <= wr_retimed || exp_pend_q
        || (gain_wait_q && !handover); // [R3] [R16]
    end
  end

  // ----------------------------------------------------------------------
  // Dark offset applied in the output coding stage
  // ----------------------------------------------------------------------
  egrb_dark_mode_t mode_now;
  egrb_offset_t ofs_sel;
  logic signed [12:0] pix_sum;

  assign mode_now = egrb_dark_mode_t'(dark_ctrl_q[1:0]);

  always_comb begin
    case (mode_now) // [R15]
      EGRB_DARK_INTERNAL: ofs_sel = i_dark_calc;
      EGRB_DARK_EXTERNAL: ofs_sel = dark_ofs_q; // [R12]
      default: ofs_sel = 11'sh000;
    endcase
    pix_sum = $signed({3'h0, i_pix}) + 13'(ofs_sel);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pix <= 10'h000;
      o_pix_valid <= 1'b0;
      o_dark_mode <= EGRB_DARK_REPORT;
      o_dark_slow <= 1'b0;
    end else begin
      o_pix_valid <= i_pix_valid;
      o_dark_mode <= mode_now;
      o_dark_slow <= dark_ctrl_q[`EGRB_DARK_SLOW_BIT];
      // Results outside the code range saturate instead of wrapping
      if (pix_sum < 0) begin
        o_pix <= 10'h000; // [R12]
      end else if (pix_sum > 13'sh3ff) begin
        o_pix <= `EGRB_PIX_MAX;
      end else begin
        o_pix <= pix_sum[9:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  hold_no_frame_a: assert property ( // [R1]
    !i_frame_start |=> $stable(o_fine_exp) && $stable(o_coarse_exp))
    else $error("exposure changed outside a frame start");

  read_back_a: assert property ( // [R2]
    (i_wr_en && i_addr == `EGRB_FINE_LO_OFS) ##1 !i_wr_en ##1
    (i_rd_en && !i_wr_en && i_addr == `EGRB_FINE_LO_OFS)
    |=> o_rdata == $past(i_wdata, 3))
    else $error("read-back differs from written value");

  pend_set_a: assert property ( // [R3]
    (i_wr_en && i_addr == `EGRB_COARSE_LO_OFS) |=> o_exp_pending [*2])
    else $error("pending not raised by exposure write");

  gain_lag_a: assert property ( // [R4]
    (handover && gain_wait_q && !i_wr_en)
    |=> o_gain_code == $past(gain_stage_q))
    else $error("staged gain not applied at next frame");

  freeze_a: assert property ( // [R5]
    (i_frame_start && i_wr_en && in_page)
    |=> $stable(o_fine_exp) && $stable(o_coarse_exp)
    && ($stable(div_act_q)
    || ($past(i_addr) == `EGRB_CLKDIV_OFS && $past(imm_div))))
    else $error("hand-over during exposure page write");

  clip_a: assert property ( // [R6]
    handover |=> o_fine_exp <= $past(i_line_max)
    && o_coarse_exp <= $past(i_frame_max))
    else $error("exposure above its limit");

  imm_gain_a: assert property ( // [R13]
    (i_wr_en && i_addr == `EGRB_GAIN_OFS && imm_gain)
    |=> o_gain_code == $past(i_wdata[3:0]))
    else $error("immediate gain not applied");

  div_ratio_a: assert property ( // [R11]
    (div_act_q == 4'h3) |=> o_clk_div_ratio == 5'd4)
    else $error("divisor code 001x not dividing by 4");

  dark_pass_a: assert property ( // [R15]
    (mode_now == EGRB_DARK_REPORT && i_pix_valid) |=> o_pix == $past(i_pix))
    else $error("report mode altered pixels");

  pend_clear_a: assert property ( // [R16]
    (handover && !gain_wait_q && !exp_pend_q) |=> !o_exp_pending)
    else $error("pending stuck after consumption");

  handover_c: cover property (wr_retimed ##[1:20] handover);
  gain_two_c: cover property (handover && exp_pend_q ##[1:50] handover);
  ext_ofs_c: cover property (mode_now == EGRB_DARK_EXTERNAL && i_pix_valid);
endmodule

/* File: test/egrb_host.sv */
// Processor model that writes and reads register bytes over the parallel register bus
`timescale 1ns/1ps
module egrb_host (
  input wire logic i_clk_sys,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_page_busy
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_page_busy = 1'b0;
  end

  // One byte per call; an idle bus shows inverted junk, never stale data
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [7:0] d);
    @(negedge i_clk_sys);
    o_wr_en = we;
    o_rd_en = ~we;
    o_addr = a;
    o_wdata = d;
    o_page_busy = (a[7:4] == 4'h2);
    @(negedge i_clk_sys);
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
    o_page_busy = 1'b0;
  endtask
endmodule

/* File: test/tb_exposure_gain_register_bank.sv */
// Self-checking bench for the exposure register bank
`timescale 1ns/1ps
module tb_exposure_gain_register_bank;
  import egrb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fs = 1'b0;
  logic pv = 1'b0;
  logic rd_seen = 1'b0;
  logic [9:0] pix = 10'h000;
  logic wr, rd, busy, slow, pend, opv;
  logic [7:0] addr, wdata, rdata;
  logic [9:0] opix;
  logic [4:0] ratio;
  egrb_exp_t fine, coarse;
  egrb_code_t gain;
  egrb_dark_mode_t mode;
  logic [7:0] exp_q[$];
  logic [31:0] rnd = 32'h96458cc6;
  int failures = 0;
  int num_checks = 0;
  int s;

  always #12.5 clk = ~clk;

  egrb_host host (.i_clk_sys(clk), .o_wr_en(wr), .o_rd_en(rd),
    .o_addr(addr), .o_wdata(wdata), .o_page_busy(busy));

  egrb_bank dut (.i_clk_sys(clk), .i_rst(rst), .i_wr_en(wr),
    .i_rd_en(rd), .i_addr(addr), .i_wdata(wdata), .i_page_busy(busy),
    .i_frame_start(fs), .i_line_max(10'h100), .i_frame_max(10'h200),
    .i_pix_valid(pv), .i_pix(pix), .i_dark_calc(11'sd20),
    .o_rdata(rdata), .o_fine_exp(fine), .o_coarse_exp(coarse),
    .o_gain_code(gain), .o_clk_div_ratio(ratio), .o_dark_mode(mode),
    .o_dark_slow(slow), .o_exp_pending(pend), .o_pix_valid(opv),
    .o_pix(opix));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [15:0] div_of(input logic [3:0] c);
    return (c == 4'h0) ? 16'h1 : (c == 4'h1) ? 16'h2 : 16'(2 * (c[3:1] + 1));
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask

  task automatic frame();
    @(negedge clk);
    fs = 1'b1;
    @(negedge clk);
    fs = 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Read data lands on the edge that samples the read and is checked half a cycle later; oldest note first
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      chk(16'(rdata), 16'(exp_q.pop_front()), "read data");
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    conclude();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (int a = 8'h20; a < 8'h30; a++) begin
      rdx(8'(a), (a == 8'h22) ? 8'h02 : (a == 8'h23) ? 8'h0a : 8'h00);
    end
    chk(16'(coarse), 16'h20a, "coarse reset");
    chk(16'(fine), 16'h0, "fine reset");
    chk(16'(gain), 16'h0, "gain reset");
    // Oversized values wait for a frame, then get clipped
    rnd = lfsr(rnd);
    host.xfer(1'b1, 8'h20, 8'hff);
    host.xfer(1'b1, 8'h21, rnd[7:0]);
    rdx(8'h21, rnd[7:0]);
    host.xfer(1'b1, 8'h22, 8'hff);
    host.xfer(1'b1, 8'h23, rnd[15:8]);
    host.xfer(1'b1, 8'h24, 8'hf5);
    host.xfer(1'b1, 8'h25, 8'h07);
    rdx(8'h20, 8'h03);
    rdx(8'h21, rnd[7:0]);
    rdx(8'h24, 8'h05);
    rdx(8'h26, 8'h01);
    chk(16'(pend), 16'h1, "pending set");
    chk(16'(fine), 16'h0, "fine held");
    chk(16'(ratio), 16'h1, "divisor held");
    fork
      host.xfer(1'b1, 8'h2e, 8'h08);
      frame();
    join
    repeat (3) @(negedge clk);
    chk(16'(coarse), 16'h20a, "frozen frame skipped");
    chk(16'(slow), 16'h1, "slow bit");
    frame();
    repeat (2) @(negedge clk);
    chk(16'(fine), 16'h100, "fine clipped");
    chk(16'(coarse), 16'h200, "coarse clipped");
    chk(16'(ratio), div_of(4'h7), "divisor at frame");
    chk(16'(gain), 16'h0, "gain one frame late");
    chk(16'(pend), 16'h1, "pending while gain waits");
    frame();
    repeat (2) @(negedge clk);
    chk(16'(gain), 16'h5, "gain applied");
    chk(16'(pend), 16'h0, "pending cleared");
    frame();
    repeat (2) @(negedge clk);
    chk(16'(pend), 16'h0, "pending stays clear");
    chk(16'(gain), 16'h5, "gain kept");
    // Immediate update modes
    host.xfer(1'b1, 8'h11, 8'h18);
    rdx(8'h11, 8'h18);
    for (int c = 0; c < 16; c++) begin
      host.xfer(1'b1, 8'h25, 8'(c));
      repeat (2) @(negedge clk);
      chk(16'(ratio), div_of(4'(c)), "immediate divisor");
    end
    rnd = lfsr(rnd);
    host.xfer(1'b1, 8'h24, {4'h0, rnd[3:0]});
    chk(16'(gain), 16'(rnd[3:0]), "immediate gain");
    chk(16'(pend), 16'h0, "no pending");
    // Dark offset of -16 against internal +20 and pass-through
    host.xfer(1'b1, 8'h2c, 8'hff);
    host.xfer(1'b1, 8'h2d, 8'hf0);
    rdx(8'h2c, 8'h07);
    for (int m = 0; m < 4; m++) begin
      if (m == 2) continue;
      host.xfer(1'b1, 8'h2e, 8'(m));
      @(negedge clk);
      chk(16'(mode), 16'(m), "dark mode");
      for (int i = 0; i < 6; i++) begin
        rnd = lfsr(rnd);
        pix = (i == 0) ? 10'h005 : (i == 1) ? 10'h3fa : rnd[9:0];
        pv = 1'b1;
        s = int'(pix) + ((m == 1) ? 20 : (m == 3) ? -16 : 0);
        @(negedge clk);
        chk(16'(opix), 16'(s < 0 ? 0 : s > 1023 ? 1023 : s), "pixel");
        chk(16'(opv), 16'h1, "pixel valid");
      end
    end
    repeat (2) @(negedge clk);
    conclude();
  end
endmodule
